// file: phy_event_status_and_error_counters.sv
// second event status bank, enables and two clear-on-read error
// counters behind an ahb-lite slave, with the combined interrupt pin.
// assumes a single hclk domain and event inputs synchronous to it.
//
// The AHB-Lite slave port was left to the implementer.
`include "phy_event_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module phy_event_status_and_error_counters #(
	parameter int FC_W = `FC_WIDTH,
	parameter int RE_W = `RE_WIDTH
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// transceiver events
	input wire phy_event_pkg::event_in_t events,
	input wire phy_event_pkg::rx_err_in_t rx_err,
	// interrupt pin, output enable low while driving
	input wire logic irq_pin_i,
	output logic irq_pin_o,
	output logic irq_pin_oe_n
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[9:2];
	endfunction : word_index

	// sticky flag: a set in the clearing cycle wins
	function automatic logic sticky(input logic cur, input logic clr,
		input logic set);
		sticky = (cur & ~clr) | set;
	endfunction : sticky

	// ----------------------------------------
	// ahb address phase decode
	// ----------------------------------------
	wire logic addr_valid;
	wire logic rd_take;
	wire logic wr_take;
	wire logic [7:0] idx;
	wire logic hit_ctl;
	wire logic hit_first;
	wire logic hit_second;
	wire logic hit_fc;
	wire logic hit_re;

	assign addr_valid = hsel & htrans[1] & hready;
	assign rd_take = addr_valid & ~hwrite;
	assign wr_take = addr_valid & hwrite;
	assign idx = word_index(haddr);
	assign hit_ctl = (idx == `IDX_IRQ_CONTROL);
	assign hit_first = (idx == `IDX_EVENT_FIRST);
	assign hit_second = (idx == `IDX_EVENT_SECOND);
	assign hit_fc = (idx == `IDX_FALSE_CARRIER);
	assign hit_re = (idx == `IDX_RX_ERROR);

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// write data phase
	// ----------------------------------------
	logic wr_pend_ff;
	logic [7:0] wr_idx_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= 8'h00;
		end else begin
			wr_pend_ff <= wr_take;
			wr_idx_ff <= idx;
		end
	end

	wire logic wr_ctl;
	wire logic wr_first;
	wire logic wr_second;

	assign wr_ctl = wr_pend_ff & (wr_idx_ff == `IDX_IRQ_CONTROL);
	assign wr_first = wr_pend_ff & (wr_idx_ff == `IDX_EVENT_FIRST);
	assign wr_second = wr_pend_ff & (wr_idx_ff == `IDX_EVENT_SECOND);

	// ----------------------------------------
	// control and enable registers
	// ----------------------------------------
	logic [3:0] ctl_ff;
	logic [7:0] en2_ff;
	logic [1:0] en1_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_ff <= `CTL_RESET;
			en2_ff <= 8'h00;
			en1_ff <= 2'h0;
		end else begin
			if (wr_ctl) begin
				ctl_ff <= hwdata[3:0];
			end
			if (wr_second) begin
				en2_ff <= hwdata[`SECOND_ENABLE_MSB:`SECOND_ENABLE_LSB];
			end
			if (wr_first) begin
				en1_ff <= {hwdata[`FIRST_FC_EN_BIT + 1 - 1],
					hwdata[`FIRST_RE_EN_BIT]};
			end
		end
	end

	// ----------------------------------------
	// second bank latched status
	// ----------------------------------------
	wire logic clr_second;
	wire logic [7:0] ev2;
	logic [7:0] st2_ff;
	logic [7:0] nxt_st2;

	assign clr_second = rd_take & hit_second;
	assign ev2[7] = events.eee_error;
	assign ev2[6] = events.an_error;
	assign ev2[5] = events.page_received;
	assign ev2[4] = events.loopback_fifo_error;
	assign ev2[3] = events.crossover_change;
	assign ev2[2] = events.sleep_event;
	assign ev2[1] = events.polarity_change | events.wol_packet;
	assign ev2[0] = events.jabber;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			nxt_st2[i] = sticky(st2_ff[i], clr_second, ev2[i]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st2_ff <= 8'h00;
		end else begin
			st2_ff <= nxt_st2;
		end
	end

	// ----------------------------------------
	// error counters
	// ----------------------------------------
	wire logic clr_fc;
	wire logic clr_re;
	wire logic fc_inc;
	wire logic re_inc;
	wire logic fc_max;
	wire logic re_max;
	logic [FC_W-1:0] fc_ff;
	logic [RE_W-1:0] re_ff;
	logic [FC_W-1:0] nxt_fc;
	logic [RE_W-1:0] nxt_re;

	assign clr_fc = rd_take & hit_fc;
	assign clr_re = rd_take & hit_re;
	assign fc_inc = rx_err.false_carrier;
	assign re_inc = rx_err.carrier_valid & rx_err.rx_dv &
		rx_err.invalid_symbol & ~rx_err.mii_loopback;
	assign fc_max = &fc_ff;
	assign re_max = &re_ff;

	// an event landing in the read cycle starts the new count at one
	always_comb begin
		if (clr_fc) begin
			nxt_fc = {{(FC_W-1){1'b0}}, fc_inc};
		end else if (fc_inc && !fc_max) begin
			nxt_fc = fc_ff + {{(FC_W-1){1'b0}}, 1'b1};
		end else begin
			nxt_fc = fc_ff;
		end
		if (clr_re) begin
			nxt_re = {{(RE_W-1){1'b0}}, re_inc};
		end else if (re_inc && !re_max) begin
			nxt_re = re_ff + {{(RE_W-1){1'b0}}, 1'b1};
		end else begin
			nxt_re = re_ff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fc_ff <= '0;
			re_ff <= '0;
		end else begin
			fc_ff <= nxt_fc;
			re_ff <= nxt_re;
		end
	end

	// ----------------------------------------
	// half-full events, latched in the first bank
	// ----------------------------------------
	// the event fires once on crossing, so a host that reads the
	// first bank but not the counter does not see it re-latch
	wire logic fc_hf_ev;
	wire logic re_hf_ev;
	wire logic clr_first;
	logic fc_hf_ff;
	logic re_hf_ff;

	assign fc_hf_ev = (nxt_fc > FC_W'(`FC_HALF_FULL)) &
		~(fc_ff > FC_W'(`FC_HALF_FULL));
	assign re_hf_ev = (nxt_re > RE_W'(`RE_HALF_FULL)) &
		~(re_ff > RE_W'(`RE_HALF_FULL));
	assign clr_first = rd_take & hit_first;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fc_hf_ff <= 1'b0;
			re_hf_ff <= 1'b0;
		end else begin
			fc_hf_ff <= sticky(fc_hf_ff, clr_first, fc_hf_ev);
			re_hf_ff <= sticky(re_hf_ff, clr_first, re_hf_ev);
		end
	end

	// ----------------------------------------
	// interrupt combine and pin
	// ----------------------------------------
	wire logic any_second;
	wire logic any_first;
	wire logic irq_req;
	wire logic irq_level;

	assign any_second = |(st2_ff & en2_ff);
	assign any_first = (fc_hf_ff & en1_ff[1]) |
		(re_hf_ff & en1_ff[0]);
	assign irq_req = ((any_second | any_first) &
		ctl_ff[`CTL_INT_EN_BIT]) | ctl_ff[`CTL_TEST_BIT];
	assign irq_level = ctl_ff[`CTL_POLARITY_BIT] ? ~irq_req :
		irq_req;

	// pin idles as an input (power-down use) until output is enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_pin_o <= 1'b1;
			irq_pin_oe_n <= 1'b1;
		end else begin
			irq_pin_o <= irq_level;
			irq_pin_oe_n <= ~ctl_ff[`CTL_OUT_EN_BIT];
		end
	end

	// ----------------------------------------
	// read data, captured at the address phase
	// ----------------------------------------
	// capturing here lets the clear-on-read act in the same cycle
	// the value is frozen, so no count is lost between the two
	wire logic [15:0] rd_ctl;
	wire logic [15:0] rd_first;
	wire logic [15:0] rd_second;
	wire logic [15:0] rd_fc;
	wire logic [15:0] rd_re;
	wire logic [15:0] rd_mux;

	assign rd_ctl = {12'h000, ctl_ff};
	assign rd_first = {6'h00, fc_hf_ff, re_hf_ff, 6'h00, en1_ff};
	assign rd_second = {st2_ff, en2_ff};
	assign rd_fc = 16'(fc_ff);
	assign rd_re = 16'(re_ff);
	assign rd_mux = hit_ctl ? rd_ctl :
		hit_first ? rd_first :
		hit_second ? rd_second :
		hit_fc ? rd_fc :
		hit_re ? rd_re : 16'h0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_take) begin
			hrdata <= {16'h0000, rd_mux};
		end
	end

	// pin input and hsize are not needed by this block
	wire logic unused_ok;
	assign unused_ok = irq_pin_i ^ (|hsize) ^ htrans[0];

endmodule : phy_event_status_and_error_counters

`default_nettype wire

// file: phy_event_regs.svh
// register map, field positions, reset values and thresholds of the
// event status bank and error counters.
// assumes inclusion by its bare name from design files.
`ifndef PHY_EVENT_REGS_SVH
`define PHY_EVENT_REGS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_IRQ_CONTROL 8'h11
`define IDX_EVENT_FIRST 8'h12
`define IDX_EVENT_SECOND 8'h13
`define IDX_FALSE_CARRIER 8'h14
`define IDX_RX_ERROR 8'h15

// ----------------------------------------
// interrupt control fields
// ----------------------------------------
`define CTL_POLARITY_BIT 3
`define CTL_TEST_BIT 2
`define CTL_INT_EN_BIT 1
`define CTL_OUT_EN_BIT 0
`define CTL_RESET 4'h8

// ----------------------------------------
// first bank fields (only the counter events live here)
// ----------------------------------------
`define FIRST_FC_HF_BIT 9
`define FIRST_RE_HF_BIT 8
`define FIRST_FC_EN_BIT 1
`define FIRST_RE_EN_BIT 0

// ----------------------------------------
// second bank fields
// ----------------------------------------
`define SECOND_STATUS_LSB 8
`define SECOND_STATUS_MSB 15
`define SECOND_ENABLE_LSB 0
`define SECOND_ENABLE_MSB 7
`define SECOND_RESET 16'h0000

// ----------------------------------------
// counters
// ----------------------------------------
`define FC_WIDTH 8
`define RE_WIDTH 16
`define FC_HALF_FULL 8'h7F
`define RE_HALF_FULL 16'h007F
`define COUNT_RESET 16'h0000

`endif

// file: phy_event_pkg.sv
// types shared by the event status block.
// assumes nothing beyond the register header.
package phy_event_pkg;

	// ----------------------------------------
	// event sources from the transceiver core, one-cycle pulses
	// ----------------------------------------
	typedef struct packed {
		logic eee_error;
		logic an_error;
		logic page_received;
		logic loopback_fifo_error;
		logic crossover_change;
		logic sleep_event;
		logic polarity_change;
		logic wol_packet;
		logic jabber;
	} event_in_t;

	// ----------------------------------------
	// receive path qualifiers for the error counters
	// ----------------------------------------
	typedef struct packed {
		logic false_carrier;
		logic carrier_valid;
		logic rx_dv;
		logic invalid_symbol;
		logic mii_loopback;
	} rx_err_in_t;

endpackage : phy_event_pkg

// file: mgmt_host.sv
// ahb-lite master standing in for the management host.
// assumes hready comes back from the one slave on the bus.
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
	// bus
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata,
	// set when a wait ran out
	output logic hung
);
	initial {hsel, haddr, htrans, hwrite, hwdata, hung} = '0;
	// never assume a wait count, only bound it
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 50) begin
			n++;
			@(posedge hclk);
		end
		if (n == 50)
			hung <= 1'b1;
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [7:0] i,
		input logic [31:0] d, output logic [31:0] r);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 22'h0, i, 2'h0};
		wait_rdy();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		wait_rdy();
		r = hrdata;
	endtask : xfer
endmodule : mgmt_host
`default_nettype wire

// file: phy_event_asserts.sv
// checker of the event bank and counters, bound to the top module.
// assumes the host leaves one idle cycle between transfers.
`timescale 1ns/1ps
`default_nettype none
module phy_event_asserts (
	// clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// events and pin
	input wire phy_event_pkg::event_in_t events,
	input wire phy_event_pkg::rx_err_in_t rx_err,
	input wire logic irq_pin_o,
	input wire logic irq_pin_oe_n
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic tk = hsel & htrans[1] & hready;
	wire logic [7:0] ix = haddr[9:2];
	wire logic r13 = tk & !hwrite & (ix == 8'h13);
	wire logic r14 = tk & !hwrite & (ix == 8'h14);
	wire logic r15 = tk & !hwrite & (ix == 8'h15);
	wire logic w13 = tk & hwrite & (ix == 8'h13);
	wire logic q13 = (events == '0);
	wire logic q14 = !rx_err.false_carrier;
	wire logic q15 = !rx_err.rx_dv;
	wire logic ql = rx_err.mii_loopback;
	property p_eee;
		events.eee_error ##2 r13 |=> hrdata[15];
	endproperty
	a_eee: assert property (p_eee) else $error("eee bit lost");
	property p_en;
		w13 ##1 !tk ##1 r13 |=> hrdata[7:0] == $past(hwdata[7:0], 2);
	endproperty
	a_en: assert property (p_en) else $error("enable readback");
	property p_fcw;
		r14 |=> hrdata[31:8] == 24'h0;
	endproperty
	a_fcw: assert property (p_fcw) else $error("fc upper bits");
	property p_fcclr;
		(r14 && q14) ##1 q14 ##1 r14 |=> hrdata == 32'h0;
	endproperty
	a_fcclr: assert property (p_fcclr) else $error("fc not cleared");
	property p_redv;
		(r15 && q15) ##1 q15 ##1 (r15 && q15) |=> hrdata == 32'h0;
	endproperty
	a_redv: assert property (p_redv) else $error("re counts idle");
	property p_relb;
		(r15 && ql) ##1 ql ##1 (r15 && ql) |=> hrdata == 32'h0;
	endproperty
	a_relb: assert property (p_relb) else $error("re in loopback");
	property p_stclr;
		(r13 && q13) ##1 q13 ##1 r13 |=> hrdata[15:8] == 8'h0;
	endproperty
	a_stclr: assert property (p_stclr) else $error("status kept");
	property p_pin;
		$rose(hresetn) |-> irq_pin_o && irq_pin_oe_n;
	endproperty
	a_pin: assert property (p_pin) else $error("pin after reset");
endmodule : phy_event_asserts
bind phy_event_status_and_error_counters phy_event_asserts u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hrdata(hrdata), .events(events), .rx_err(rx_err),
	.irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n));
`default_nettype wire

// file: test_phy_event_status_and_error_counters.sv
// bench of the event bank and counters against an integer model.
// assumes the host model as bus master and a pulled-up irq wire.
`timescale 1ns/1ps
`default_nettype none
module test_phy_event_status_and_error_counters;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hung, hreadyout, hresp, irq_pin_o, irq_pin_oe_n;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans;
	wire logic irq_wire = irq_pin_oe_n ? 1'b1 : irq_pin_o;
	phy_event_pkg::event_in_t events = '0;
	phy_event_pkg::rx_err_in_t rx_err = '0;
	int fails = 0;
	int total_checks = 0;
	int fc = 0, re = 0, st = 0, fhf = 0, rhf = 0, en;
	always #5 hclk = ~hclk;
	mgmt_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hwdata(hwdata), .hung(hung));
	phy_event_status_and_error_counters dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .events(events),
		.rx_err(rx_err), .irq_pin_i(irq_wire), .irq_pin_o(irq_pin_o),
		.irq_pin_oe_n(irq_pin_oe_n));
	task automatic end_of_test();
		$display("fails %0d total_checks %0d", fails, total_checks);
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic acc(input logic w, input logic [7:0] i,
		input logic [31:0] d, input logic [31:0] e);
		host.xfer(w, i, d, v);
		check("hresp", {31'h0, hresp}, 32'h0);
		if (!w)
			check("hrdata", v, e);
		if (hung === 1'b1) begin
			fails++;
			end_of_test();
		end
	endtask : acc
	task automatic irq_is(input logic e);
		@(posedge hclk);
		#1;
		check("irq", irq_wire, e);
	endtask : irq_is
	// holds the sources n cycles, then folds them into the model
	task automatic drive(input logic [8:0] e, input logic [4:0] r, input int n);
		events <= e;
		rx_err <= r;
		repeat (n) @(posedge hclk);
		events <= '0;
		rx_err <= r & 5'h01;
		@(posedge hclk);
		for (int i = 0; i < 9; i++)
			if (e[i])
				st = st | (1 << ((i > 1) ? i + 7 : i + 8));
		if (r[4] && fc <= 127 && fc + n > 127)
			fhf = 1;
		if (r[4])
			fc = (fc + n > 255) ? 255 : fc + n;
		if (r[3:0] == 4'hE && re <= 127 && re + n > 127)
			rhf = 1;
		if (r[3:0] == 4'hE)
			re = (re + n > 65535) ? 65535 : re + n;
	endtask : drive
	initial begin
		repeat (100000) @(posedge hclk);
		fails++;
		end_of_test();
	end
	initial begin
		void'($urandom(31));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		acc(1'b0, 8'h11, 32'h0, 32'h8);
		for (int i = 8'h12; i < 8'h17; i++)
			acc(1'b0, i[7:0], 32'h0, 32'h0);
		for (int i = 0; i < 9; i++) begin
			en = $urandom_range(255);
			acc(1'b1, 8'h13, en, 32'h0);
			acc(1'b0, 8'h13, 32'h0, en);
			drive(9'h1 << i, 5'h0, 1);
			acc(1'b0, 8'h13, 32'h0, st | en);
			st = 0;
			acc(1'b0, 8'h13, 32'h0, en);
		end
		acc(1'b1, 8'h13, 32'h1, 32'h0);
		acc(1'b1, 8'h11, 32'hB, 32'h0);
		drive(9'h1, 5'h0, 1);
		irq_is(1'b0);
		acc(1'b0, 8'h13, 32'h0, 32'h101);
		irq_is(1'b1);
		acc(1'b1, 8'h11, 32'h9, 32'h0);
		drive(9'h1, 5'h0, 1);
		irq_is(1'b1);
		acc(1'b0, 8'h13, 32'h0, 32'h101);
		acc(1'b1, 8'h12, 32'h2, 32'h0);
		acc(1'b1, 8'h11, 32'hB, 32'h0);
		drive(9'h0, 5'h10, 127);
		irq_is(1'b1);
		drive(9'h0, 5'h10, 1);
		irq_is(1'b0);
		acc(1'b0, 8'h12, 32'h0, (fhf << 9) | 2);
		fhf = 0;
		drive(9'h0, 5'h10, 200);
		acc(1'b0, 8'h14, 32'h0, fc);
		fc = 0;
		acc(1'b0, 8'h14, 32'h0, fc);
		for (int i = 0; i < 30; i++)
			drive(9'h0, 5'($urandom_range(31)), 1 + $urandom_range(1));
		acc(1'b0, 8'h15, 32'h0, re);
		re = 0;
		acc(1'b0, 8'h14, 32'h0, fc);
		fc = 0;
		drive(9'h0, 5'h0E, 65600);
		acc(1'b0, 8'h15, 32'h0, re);
		acc(1'b0, 8'h12, 32'h0, (fhf << 9) | (rhf << 8) | 2);
		end_of_test();
	end
endmodule : test_phy_event_status_and_error_counters
`default_nettype wire
